// *** logic/vcct_device.sv ***
/*
 * Codec control block: serial slave port, seven configuration registers,
 * power/path decode, receive frame deserialiser, dual tone generator and
 * pulse-density buzzer stream.
 * Assumes all pins are asynchronous to clk_i and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vcct_regs.svh"

// Behaviour
// - frame slots: 8 or 15 bits MSB first
// - tone codes held in registers 04 and 05
// - high tone output 2 dB above low
// - master puts higher frequency in high register
// - aux bits 2-5 set tone frequency step
// - low tone peak 31, word peak 3968
// - high tone peak 39, word peak 4992
// - summed tones peak 70, word peak 8960
// - tones everywhere, gated by each output's enable
// - buzzer is pulse-density stream of tone
// - slave only, only while select high
// - fixed write and read select bytes
// - data changes with clock low; start/stop
// - master frames transfers, decides byte count
// - acknowledge low through ninth clock high
// - master withholds last read ack; release
// - sample rate set by frame sync
// - power default chosen by power-up pin
// - power bits 0,1: reference, earphone choice
// - receive enable, mute, power down decode
// - transmit enable, mute, power down decode
// - step codes 00,01,10 per tone
// - linear 15-bit or companded 8-bit samples
module vcct_device
	import vcct_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	vcct_if.device           bus,
	input  wire logic        powerup_default_pin_i,
	input  wire logic        frame_sync_in_i,
	input  wire logic        pcm_clk_i,
	input  wire logic        pcm_data_i,
	output logic      [14:0] rx_word_o,
	output logic             rx_word_valid_o,
	output logic             buzzer_o,
	output logic             reference_power_o,
	output logic             ear1_select_o,
	output logic             rx_enable_o,
	output logic             rx_mute_o,
	output logic             rx_down_o,
	output logic             tx_enable_o,
	output logic             tx_mute_o,
	output logic             tx_down_o,
	output logic             mic_bias_o,
	output logic             mic1_select_o,
	output logic             sidetone_mute_o
);
	vcct_byte_t     regs_q [`VCCT_NUM_REGS];
	logic     [6:0] s1_q, s2_q, s3_q;
	logic     [1:0] init_q;
	vcct_dev_st_t   st_q;
	logic     [3:0] bit_q;
	logic     [1:0] idx_q;
	logic     [7:0] sh_q;
	logic     [2:0] ptr_q;
	logic           rd_mode_q, acked_q, sda_oe_q, sda_out_q;
	logic     [4:0] slot_q;
	logic    [14:0] psh_q, pcm_word_q;
	logic     [9:0] lo_ph_q, hi_ph_q;
	logic    [14:0] acc_q;
	logic           scl, sda, cs, pin_sync, fs, pclk, pdat;
	logic           scl_rise, scl_fall, start_c, stop_c, fs_rise, pclk_fall;
	logic           byte_end, wr_stb, ptr_ld, tx_next;
	logic           tone_mode, comp_mode;
	logic     [4:0] nbits;
	logic     [7:0] rd_byte;
	logic signed [7:0] lo_val, hi_val, sum_val;
	logic    [14:0] tone_word;
	logic    [15:0] acc_sum;

	// every pin passes three flops; only stage two and three feed logic
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_q <= 7'h5b;  // pcm clock parked low so no false fall follows reset
			s2_q <= 7'h5b;
			s3_q <= 7'h5b;
		end else begin
			s1_q <= {pcm_data_i, pcm_clk_i, frame_sync_in_i, powerup_default_pin_i,
				bus.cs, bus.sda, bus.scl};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign {pdat, pclk, fs, pin_sync, cs, sda, scl} = s2_q;
	assign scl_rise  = scl & ~s3_q[0];
	assign scl_fall  = ~scl & s3_q[0];
	assign start_c   = scl & s3_q[0] & ~sda & s3_q[1];
	assign stop_c    = scl & s3_q[0] & sda & ~s3_q[1];
	assign fs_rise   = fs & ~s3_q[4];
	assign pclk_fall = ~pclk & s3_q[5];
	assign tone_mode = regs_q[`VCCT_REG_MODE][`VCCT_MODE_TONE];
	assign comp_mode = regs_q[`VCCT_REG_MODE][`VCCT_MODE_COMP];

	// a byte is complete at the falling clock edge after its eighth bit
	assign byte_end = cs & ~start_c & ~stop_c & (st_q == VD_RX) & scl_fall & (bit_q == 4'd8);
	assign wr_stb   = byte_end & (idx_q == 2'd2) & ~rd_mode_q;
	assign ptr_ld   = byte_end & (idx_q == 2'd1);
	assign tx_next  = cs & ~stop_c & ~start_c & (st_q == VD_TX) & scl_fall & (bit_q == 4'd8);
	assign rd_byte  = (ptr_q < 3'(`VCCT_NUM_REGS)) ? regs_q[ptr_q] : 8'h00;

	// serial slave sequencer; it never drives the clock
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q      <= VD_IDLE;
			bit_q     <= 4'h0;
			idx_q     <= 2'h0;
			sh_q      <= 8'h00;
			rd_mode_q <= 1'b0;
			acked_q   <= 1'b0;
			sda_oe_q  <= 1'b0;
		end else if (!cs || stop_c) begin
			st_q     <= VD_IDLE;
			sda_oe_q <= 1'b0;
		end else if (start_c) begin
			st_q     <= VD_RX;
			bit_q    <= 4'h0;
			idx_q    <= 2'h0;
			sda_oe_q <= 1'b0;
		end else begin
			case (st_q)
				VD_RX: begin
					if (scl_rise && bit_q != 4'd8) begin
						sh_q  <= {sh_q[6:0], sda};
						bit_q <= bit_q + 4'h1;
					end else if (byte_end) begin
						bit_q <= 4'h0;
						if (idx_q != 2'd2)
							idx_q <= idx_q + 2'h1;
						if (idx_q != 2'd0 || sh_q[7:1] == 7'(`VCCT_SEL_WRITE >> 1)) begin
							st_q     <= VD_ACK;
							sda_oe_q <= 1'b1;
							if (idx_q == 2'd0)
								rd_mode_q <= sh_q[0];
						end else begin
							st_q <= VD_IDLE;
						end
					end
				end
				VD_ACK: begin
					if (scl_fall && rd_mode_q) begin
						st_q     <= VD_TX;
						sh_q     <= rd_byte;
						sda_oe_q <= ~rd_byte[7];
						bit_q    <= 4'h1;
					end else if (scl_fall) begin
						st_q     <= VD_RX;
						sda_oe_q <= 1'b0;
					end
				end
				VD_TX: begin
					if (tx_next) begin
						st_q     <= VD_TACK;
						sda_oe_q <= 1'b0;
					end else if (scl_fall) begin
						sda_oe_q <= ~sh_q[6];
						sh_q     <= {sh_q[6:0], 1'b0};
						bit_q    <= bit_q + 4'h1;
					end
				end
				VD_TACK: begin
					if (scl_rise) begin
						acked_q <= ~sda;
					end else if (scl_fall && acked_q) begin
						st_q     <= VD_TX;
						sh_q     <= rd_byte;
						sda_oe_q <= ~rd_byte[7];
						bit_q    <= 4'h1;
					end else if (scl_fall) begin
						st_q <= VD_IDLE;
					end
				end
				default: st_q <= VD_IDLE;
			endcase
		end
	end

	// register pointer auto-increments after each data byte
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			ptr_q <= 3'h0;
		else if (ptr_ld)
			ptr_q <= sh_q[2:0];
		else if (wr_stb || tx_next)
			ptr_q <= ptr_q + 3'h1;
	end

	// register file; power default follows the synchronised pin once out of reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			init_q <= 2'h0;
			regs_q[`VCCT_REG_POWER]   <= `VCCT_RST_POWER_PIN0;
			regs_q[`VCCT_REG_MODE]    <= `VCCT_RST_MODE;
			regs_q[`VCCT_REG_TXGAIN]  <= `VCCT_RST_TXGAIN;
			regs_q[`VCCT_REG_RXGAIN]  <= `VCCT_RST_RXGAIN;
			regs_q[`VCCT_REG_HI_TONE] <= `VCCT_RST_TONE;
			regs_q[`VCCT_REG_LO_TONE] <= `VCCT_RST_TONE;
			regs_q[`VCCT_REG_AUX]     <= `VCCT_RST_AUX;
		end else if (init_q != 2'd3) begin
			init_q <= init_q + 2'h1;
			if (init_q == 2'd2)
				regs_q[`VCCT_REG_POWER] <= pin_sync ? `VCCT_RST_POWER_PIN1 :
					`VCCT_RST_POWER_PIN0;
		end else if (wr_stb && ptr_q < 3'(`VCCT_NUM_REGS)) begin
			regs_q[ptr_q] <= sh_q;
		end
	end

	// power and path decode, registered for clean outputs
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			{reference_power_o, ear1_select_o, rx_enable_o, rx_mute_o, rx_down_o} <= 5'h00;
			{tx_enable_o, tx_mute_o, tx_down_o, mic_bias_o} <= 4'h0;
			{mic1_select_o, sidetone_mute_o} <= 2'h0;
		end else begin
			reference_power_o <= regs_q[0][`VCCT_PWR_REF];
			ear1_select_o     <= regs_q[0][`VCCT_PWR_EAR1];
			rx_enable_o <= ~regs_q[0][`VCCT_PWR_RX];
			rx_mute_o   <= regs_q[0][`VCCT_PWR_RX] & ~(regs_q[0][`VCCT_PWR_RXTX]
				& ~regs_q[0][`VCCT_PWR_REF]);
			rx_down_o   <= regs_q[0][`VCCT_PWR_RX] & regs_q[0][`VCCT_PWR_RXTX]
				& ~regs_q[0][`VCCT_PWR_REF];
			tx_enable_o <= ~regs_q[0][`VCCT_PWR_TX];
			tx_mute_o   <= regs_q[0][`VCCT_PWR_TX] & ~regs_q[0][`VCCT_PWR_RXTX];
			tx_down_o   <= regs_q[0][`VCCT_PWR_TX] & regs_q[0][`VCCT_PWR_RXTX];
			mic_bias_o      <= regs_q[0][`VCCT_PWR_BIAS];
			mic1_select_o   <= regs_q[0][`VCCT_PWR_MIC1];
			sidetone_mute_o <= regs_q[0][`VCCT_PWR_SIDE];
		end
	end

	// receive frame: slot 1 is the first pcm clock fall after frame sync rises
	assign nbits = comp_mode ? `VCCT_COMP_BITS : `VCCT_LIN_BITS;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			slot_q     <= 5'h00;
			psh_q      <= 15'h0000;
			pcm_word_q <= 15'h0000;
		end else if (fs_rise) begin
			slot_q <= 5'h01;
		end else if (pclk_fall && slot_q != 5'h00) begin
			if (slot_q <= nbits)
				psh_q <= {psh_q[13:0], pdat};
			if (slot_q == nbits)
				pcm_word_q <= comp_mode ? {7'h00, psh_q[6:0], pdat} : {psh_q[13:0], pdat};
			slot_q <= (slot_q == `VCCT_SLOTS) ? 5'h00 : slot_q + 5'h01;
		end
	end

	// quarter-wave table, rounded into the requested peak code
	function automatic logic signed [7:0] vcct_tone(input logic [9:0] ph, input logic [8:0] pk);
		logic [3:0]  ix;
		logic [7:0]  mag;
		logic [16:0] prod;
		ix = ph[8] ? ~ph[7:4] : ph[7:4];
		case (ix)
			4'h0: mag = 8'h19;  4'h1: mag = 8'h32;  4'h2: mag = 8'h4a;  4'h3: mag = 8'h62;
			4'h4: mag = 8'h79;  4'h5: mag = 8'h8e;  4'h6: mag = 8'ha2;  4'h7: mag = 8'hb5;
			4'h8: mag = 8'hc6;  4'h9: mag = 8'hd5;  4'ha: mag = 8'he2;  4'hb: mag = 8'hed;
			4'hc: mag = 8'hf5;  4'hd: mag = 8'hfb;  4'he: mag = 8'hfe;  default: mag = 8'hff;
		endcase
		prod = 17'(mag * pk) + 17'h00080;
		vcct_tone = ph[9] ? -$signed({1'b0, prod[14:8]}) : $signed({1'b0, prod[14:8]});
	endfunction

	// a zero code silences that tone; both codes sum into one word
	assign lo_val  = (regs_q[`VCCT_REG_LO_TONE] == 8'h00) ? 8'sh00 :
		vcct_tone(lo_ph_q, `VCCT_LO_PEAK);
	assign hi_val  = (regs_q[`VCCT_REG_HI_TONE] == 8'h00) ? 8'sh00 :
		vcct_tone(hi_ph_q, `VCCT_HI_PEAK);
	assign sum_val = lo_val + hi_val;
	assign tone_word = {sum_val, 7'h00};

	// one step of 7.8125 Hz is 1/1024 of the frame rate; step code 11 acts as 10
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lo_ph_q <= 10'h000;
			hi_ph_q <= 10'h000;
		end else if (fs_rise) begin
			lo_ph_q <= lo_ph_q + ({2'h0, regs_q[`VCCT_REG_LO_TONE]}
				<< (regs_q[`VCCT_REG_AUX][`VCCT_AUX_LO_STEP+1] ? 2'd2 :
				{1'b0, regs_q[`VCCT_REG_AUX][`VCCT_AUX_LO_STEP]}));
			hi_ph_q <= hi_ph_q + ({2'h0, regs_q[`VCCT_REG_HI_TONE]}
				<< (regs_q[`VCCT_REG_AUX][`VCCT_AUX_HI_STEP+1] ? 2'd2 :
				{1'b0, regs_q[`VCCT_REG_AUX][`VCCT_AUX_HI_STEP]}));
		end
	end

	// receive output per frame: tone replaces data in tone mode, enable gates both
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_word_o       <= 15'h0000;
			rx_word_valid_o <= 1'b0;
		end else begin
			rx_word_valid_o <= fs_rise;
			if (fs_rise)
				rx_word_o <= regs_q[0][`VCCT_PWR_RX] ? 15'h0000 :
					(tone_mode ? tone_word : pcm_word_q);
		end
	end

	// first-order modulator on the tone word; only a hard zero when disabled
	assign acc_sum = {1'b0, acc_q} + {1'b0, ~tone_word[14], tone_word[13:0]};
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			acc_q    <= 15'h0000;
			buzzer_o <= 1'b0;
		end else begin
			acc_q    <= acc_sum[14:0];
			buzzer_o <= acc_sum[15] & regs_q[`VCCT_REG_MODE][`VCCT_MODE_BUZZ];
		end
	end

	// open drain: the data value is always low, only the enable moves
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			sda_out_q <= 1'b0;
		else
			sda_out_q <= 1'b0;
	end
	assign bus.sda_d_o  = sda_out_q;
	assign bus.sda_d_oe = sda_oe_q;

endmodule // vcct_device

`default_nettype wire

// *** logic/vcct_host.sv ***
/*
 * Master end of the codec control link: a command FIFO feeding a two-wire
 * bus sequencer that performs register writes and single-byte reads.
 * Assumes the slave never stretches the clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vcct_regs.svh"

module vcct_fifo #(
	parameter int W     = 12,
	parameter int DEPTH = 16
) (
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	output logic              out_valid_o,
	output logic      [W-1:0] out_data_o,
	input  wire logic         out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0]   cnt_q;
	logic          push, pop;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		$error("fifo depth must be a power of two");

	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_valid_o = (cnt_q != '0);
	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_data_o  = mem[rp_q];

	// storage writes carry no reset
	always_ff @(posedge clk_i) begin
		if (push)
			mem[wp_q] <= in_data_i;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_q + AW'(push);
			rp_q  <= rp_q + AW'(pop);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // vcct_fifo

module vcct_host
	import vcct_pkg::*;
#(
	parameter int QTR = `VCCT_SCL_QTR
) (
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	vcct_if.host            bus,
	input  wire logic       cmd_valid_i,
	input  wire logic       cmd_read_i,
	input  wire logic [2:0] cmd_addr_i,
	input  wire logic [7:0] cmd_data_i,
	output logic            cmd_ready_o,
	output logic      [7:0] rd_data_o,
	output logic            rd_valid_o,
	output logic            nack_o,
	output logic            busy_o
);
	vcct_host_st_t st_q;
	logic [11:0] cmd_q;
	logic [11:0] f_data;
	logic        f_valid, f_ready, pop;
	logic [15:0] qc_q;
	logic [1:0]  ph_q, byte_q;
	logic [3:0]  bit_q;
	logic [7:0]  rsh_q, cur;
	logic        scl_q, sda_q, nak_q, cs_q, s1_q, s2_q, tick;

	if (QTR < 2 || QTR > 65535)
		$error("quarter period out of range");

	vcct_fifo #(.W(12), .DEPTH(16)) u_fifo (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (cmd_valid_i),
		.in_data_i   ({cmd_read_i, cmd_addr_i, cmd_data_i}),
		.in_ready_o  (f_ready),
		.out_valid_o (f_valid),
		.out_data_o  (f_data),
		.out_ready_i (pop)
	);

	assign pop  = (st_q == VH_IDLE) & f_valid;
	assign tick = (qc_q == 16'(QTR - 1));

	// write: select, address, data; read: select, address, restart, select, data
	always_comb begin
		case (byte_q)
			2'd0: cur = `VCCT_SEL_WRITE;
			2'd1: cur = {5'h00, cmd_q[10:8]};
			2'd2: cur = cmd_q[11] ? `VCCT_SEL_READ : cmd_q[7:0];
			default: cur = 8'hff;
		endcase
	end

	// data line back through two flops
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
		end else begin
			s1_q <= bus.sda;
			s2_q <= s1_q;
		end
	end

	// quarter-bit timebase, held at zero while idle
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			qc_q <= 16'h0000;
		else if (st_q == VH_IDLE || tick)
			qc_q <= 16'h0000;
		else
			qc_q <= qc_q + 16'h0001;
	end

	// bus sequencer: four quarter phases per bit, ninth bit is the acknowledge
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= VH_IDLE;
			{scl_q, sda_q, nak_q, rd_valid_o, nack_o} <= 5'b11000;
			{ph_q, byte_q, bit_q} <= 8'h00;
			cmd_q <= 12'h000;
			rsh_q <= 8'h00;
			rd_data_o <= 8'h00;
		end else begin
			rd_valid_o <= 1'b0;
			nack_o     <= 1'b0;
			if (pop) begin
				cmd_q  <= f_data;
				st_q   <= VH_START;
				byte_q <= 2'd0;
				ph_q   <= 2'd0;
			end else if (tick) begin
				ph_q <= ph_q + 2'd1;
				case (st_q)
					VH_START: begin
						case (ph_q)
							2'd0: sda_q <= 1'b1;
							2'd1: scl_q <= 1'b1;
							2'd2: sda_q <= 1'b0;
							default: begin
								scl_q <= 1'b0;
								st_q  <= VH_BIT;
								bit_q <= 4'h0;
							end
						endcase
					end
					VH_BIT: begin
						case (ph_q)
							2'd0: sda_q <= (bit_q[3] || byte_q == 2'd3) ? 1'b1 :
								cur[3'd7 - bit_q[2:0]];
							2'd1: scl_q <= 1'b1;
							2'd2: begin
								if (!bit_q[3])
									rsh_q <= {rsh_q[6:0], s2_q};
								else
									nak_q <= s2_q;
							end
							default: begin
								scl_q <= 1'b0;
								bit_q <= bit_q + 4'h1;
								if (bit_q[3]) begin
									byte_q <= byte_q + 2'd1;
									if (nak_q && byte_q != 2'd3) begin
										nack_o <= 1'b1;
										st_q   <= VH_STOP;
									end else if (cmd_q[11] && byte_q == 2'd1) begin
										st_q <= VH_START;
									end else if (byte_q == 2'd3) begin
										rd_data_o  <= rsh_q;
										rd_valid_o <= 1'b1;
										st_q       <= VH_STOP;
									end else if (!cmd_q[11] && byte_q == 2'd2) begin
										st_q <= VH_STOP;
									end
									bit_q <= 4'h0;
								end
							end
						endcase
					end
					VH_STOP: begin
						case (ph_q)
							2'd0: sda_q <= 1'b0;
							2'd1: scl_q <= 1'b1;
							2'd2: sda_q <= 1'b1;
							default: st_q <= VH_IDLE;
						endcase
					end
					default: st_q <= VH_IDLE;
				endcase
			end
		end
	end

	// registered status; select is raised only around a transfer so the slave idles between
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_o      <= 1'b0;
			cmd_ready_o <= 1'b0;
			cs_q        <= 1'b0;
		end else begin
			busy_o      <= (st_q != VH_IDLE) | f_valid;
			cmd_ready_o <= f_ready;
			cs_q        <= (st_q != VH_IDLE) | f_valid;
		end
	end

	assign bus.scl_o    = 1'b0;
	assign bus.scl_oe   = ~scl_q;
	assign bus.sda_h_o  = 1'b0;
	assign bus.sda_h_oe = ~sda_q;
	assign bus.cs       = cs_q;

endmodule // vcct_host

`default_nettype wire

// *** logic/vcct_if.sv ***
/*
 * Two-wire control link between the codec control block and its master.
 * Both wires are open drain with pull-ups; the wire levels are resolved here.
 */
`timescale 1ns/1ps
`default_nettype none

interface vcct_if;
	logic scl_o;      // master clock drive value
	logic scl_oe;     // master pulls clock
	logic sda_h_o;    // master data drive value
	logic sda_h_oe;   // master pulls data
	logic sda_d_o;    // device data drive value
	logic sda_d_oe;   // device pulls data
	logic cs;         // interface select, high enables the slave
	logic scl;
	logic sda;

	// pull-up wins unless some end drives low
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

	modport host (output scl_o, scl_oe, sda_h_o, sda_h_oe, cs, input scl, sda);
	modport device (output sda_d_o, sda_d_oe, input scl, sda, cs);
endinterface

`default_nettype wire

// *** logic/vcct_pkg.sv ***
/*
 * Types shared by both ends of the voice codec control link.
 * Assumes the constants of vcct_regs.svh.
 */
`default_nettype none

package vcct_pkg;

	// device serial port states
	typedef enum logic [4:0] {
		VD_IDLE = 5'b00001,
		VD_RX   = 5'b00010,
		VD_ACK  = 5'b00100,
		VD_TX   = 5'b01000,
		VD_TACK = 5'b10000
	} vcct_dev_st_t;

	// master sequencer states
	typedef enum logic [3:0] {
		VH_IDLE  = 4'b0001,
		VH_START = 4'b0010,
		VH_BIT   = 4'b0100,
		VH_STOP  = 4'b1000
	} vcct_host_st_t;

	typedef logic [7:0] vcct_byte_t;

endpackage

`default_nettype wire

// *** logic/vcct_regs.svh ***
/*
 * Register offsets, reset values, field positions and timing counts of the
 * voice codec control block.
 * Assumes a 40 MHz core clock on both ends of the two-wire control link.
 */
`ifndef VCCT_REGS_SVH
`define VCCT_REGS_SVH

// register offsets
`define VCCT_REG_POWER      3'h0
`define VCCT_REG_MODE       3'h1
`define VCCT_REG_TXGAIN     3'h2
`define VCCT_REG_RXGAIN     3'h3
`define VCCT_REG_HI_TONE    3'h4
`define VCCT_REG_LO_TONE    3'h5
`define VCCT_REG_AUX        3'h6
`define VCCT_NUM_REGS       7

// reset values; power control depends on the power-up default pin
`define VCCT_RST_POWER_PIN0 8'hf6
`define VCCT_RST_POWER_PIN1 8'h9b
`define VCCT_RST_MODE       8'h02
`define VCCT_RST_TXGAIN     8'h40
`define VCCT_RST_RXGAIN     8'ha0
`define VCCT_RST_TONE       8'h00
`define VCCT_RST_AUX        8'h00

// power control bits
`define VCCT_PWR_REF        0
`define VCCT_PWR_EAR1       1
`define VCCT_PWR_RX         2
`define VCCT_PWR_BIAS       3
`define VCCT_PWR_MIC1       4
`define VCCT_PWR_RXTX       5
`define VCCT_PWR_TX         6
`define VCCT_PWR_SIDE       7

// mode control and auxiliary bits
`define VCCT_MODE_BUZZ      3
`define VCCT_MODE_COMP      4
`define VCCT_MODE_TONE      6
`define VCCT_AUX_LO_STEP    2
`define VCCT_AUX_HI_STEP    4

// select bytes of the serial port
`define VCCT_SEL_WRITE      8'he2
`define VCCT_SEL_READ       8'he3

// frame layout and tone scaling
`define VCCT_LIN_BITS       5'd15
`define VCCT_COMP_BITS      5'd8
`define VCCT_SLOTS          5'd16
`define VCCT_LO_PEAK        9'd31
`define VCCT_HI_PEAK        9'd39
`define VCCT_WORD_SHIFT     7

// serial clock timing
`define VCCT_CLK_PERIOD_NS  25
`define VCCT_SCL_PERIOD_NS  10000
`define VCCT_SCL_QTR        (`VCCT_SCL_PERIOD_NS / (4 * `VCCT_CLK_PERIOD_NS))

`endif

// *** verification/vcct_bench.sv ***
/* vcct_bench: host end drives register traffic into the device end.
   assumes logic/ on the include path and host QTR of 4. */
`timescale 1ns/1ps
`default_nettype none
`define VB_CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module vcct_bench;
	import vcct_pkg::*;
	logic       clk_i = 1'b0, reset_n_i = 1'b0, pin = 1'b0, fs = 1'b0, cv = 1'b0, crd = 1'b0;
	logic [2:0] ca = 3'h0, pwx;
	logic       pck = 1'b0, pd = 1'b0, bz;
	vcct_byte_t cd = 8'h00, rdat, rd_q, pwr;
	logic       rdv, cready, busy, wv;
	logic [14:0] word, wmax, wabs;
	int         bad_count = 0, n_compared = 0, cyc = 0, bz_n = 0;
	vcct_byte_t dflt [8] = '{8'hf6, 8'h02, 8'h40, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00};
	vcct_byte_t pv [4] = '{8'hac, 8'h54, 8'he7, 8'h03};
	vcct_byte_t pe [4] = '{8'h0c, 8'h12, 8'hd1, 8'he4};
	vcct_if bus ();
	vcct_host #(.QTR(4)) i_vcct_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(bus),
		.cmd_valid_i(cv), .cmd_read_i(crd), .cmd_addr_i(ca), .cmd_data_i(cd),
		.cmd_ready_o(cready), .rd_data_o(rdat), .rd_valid_o(rdv), .nack_o(), .busy_o(busy));
	// pcm pins are driven by the pcm task below
	vcct_device i_vcct_device (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(bus),
		.powerup_default_pin_i(pin), .frame_sync_in_i(fs), .pcm_clk_i(pck),
		.pcm_data_i(pd), .rx_word_o(word), .rx_word_valid_o(wv), .buzzer_o(bz),
		.reference_power_o(pwr[7]), .ear1_select_o(pwr[6]), .rx_enable_o(pwr[5]),
		.rx_mute_o(pwr[4]), .rx_down_o(pwr[3]), .tx_enable_o(pwr[2]), .tx_mute_o(pwr[1]),
		.tx_down_o(pwr[0]), .mic_bias_o(pwx[0]), .mic1_select_o(pwx[1]),
		.sidetone_mute_o(pwx[2]));
	vcct_chk i_vcct_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .scl(bus.scl),
		.sda(bus.sda), .cs(bus.cs), .sda_d_oe(bus.sda_d_oe));
	always #12.5 clk_i = ~clk_i;
	// tone words are twos complement, so the peak is tracked by magnitude
	assign wabs = word[14] ? -word : word;
	// read capture, peak tracking, buzzer ones count and hang guard
	always @(posedge clk_i) begin
		if (rdv === 1'b1) rd_q <= rdat;
		if (wv === 1'b1 && wabs > wmax) wmax <= wabs;
		if (bz === 1'b1) bz_n++;
		cyc++;
		if (cyc == 95000) begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// one command through the fifo, then wait out the bus transfer
	task automatic xfer(input logic r, input logic [2:0] a, input vcct_byte_t d);
		@(negedge clk_i);
		{cv, crd, ca, cd} = {1'b1, r, a, d};
		do @(posedge clk_i); while (cready !== 1'b1);
		@(negedge clk_i);
		cv = 1'b0;
		repeat (3) @(negedge clk_i);
		for (int i = 0; i < 3000 && busy === 1'b1; i++) @(negedge clk_i);
	endtask
	task automatic rd(input logic [2:0] a, input vcct_byte_t e);
		rd_q = 8'hxx;
		xfer(1'b1, a, 8'h00);
		`VB_CHK("reg read", e, rd_q)
	endtask
	task automatic do_reset(input logic p);
		reset_n_i = 1'b0;
		pin = p;
		repeat (4) @(negedge clk_i);
		reset_n_i = 1'b1;
		repeat (12) @(negedge clk_i);
	endtask
	// 8 khz frames; tone steps of 128 reach the sine peak by the fourth
	task automatic frames(input vcct_byte_t lo, input vcct_byte_t hi);
		xfer(1'b0, 3'h5, lo);
		xfer(1'b0, 3'h4, hi);
		wmax = 15'h0000;
		repeat (4) begin
			fs = 1'b1;
			repeat (8) @(negedge clk_i);
			fs = 1'b0;
			repeat (4992) @(negedge clk_i);
		end
	endtask
	// one frame of 16 slots, msb first, 200 ns pcm clock; the next frame rise delivers it
	task automatic pcm(input logic [15:0] v, input logic [14:0] e);
		for (int i = 0; i < 16; i++) begin
			{fs, pck, pd} = {i == 0, 1'b1, v[15-i]};
			repeat (4) @(negedge clk_i);
			pck = 1'b0;
			repeat (4) @(negedge clk_i);
		end
		fs = 1'b1;
		repeat (8) @(negedge clk_i);
		fs = 1'b0;
		`VB_CHK("pcm word", e, word)
	endtask
	initial begin
		do_reset(1'b0);
		for (int k = 0; k < 8; k++) rd(3'(k), dflt[k]);
		do_reset(1'b1);
		rd(3'h0, 8'h9b);
		for (int k = 0; k < 4; k++) begin
			xfer(1'b0, 3'h0, pv[k]);
			`VB_CHK("power decode", pe[k], pwr)
			`VB_CHK("power misc", {pv[k][7], pv[k][4], pv[k][3]}, pwx)
			rd(3'h0, pv[k]);
		end
		for (int k = 2; k >= 0; k--) begin
			xfer(1'b0, 3'h6, {2'b00, 2'(k), 2'(k), 2'b00});
			rd(3'h6, {2'b00, 2'(k), 2'(k), 2'b00});
		end
		xfer(1'b0, 3'h1, 8'h40);
		frames(8'h80, 8'h00);
		`VB_CHK("low peak", 15'd3968, wmax)
		xfer(1'b0, 3'h6, 8'h18);
		frames(8'h00, 8'h40);
		`VB_CHK("high peak", 15'd4992, wmax)
		frames(8'h20, 8'h40);
		`VB_CHK("dual peak", 15'd8960, wmax)
		xfer(1'b0, 3'h1, 8'h00);
		pcm({15'h5a3c, 1'b1}, 15'h5a3c);
		xfer(1'b0, 3'h1, 8'h10);
		pcm({8'hc5, 8'hff}, 15'h00c5);
		xfer(1'b0, 3'h4, 8'h00);
		xfer(1'b0, 3'h5, 8'h00);
		bz_n = 0;
		repeat (2048) @(negedge clk_i);
		`VB_CHK("buzzer off", 0, bz_n)
		xfer(1'b0, 3'h1, 8'h48);
		bz_n = 0;
		repeat (2048) @(negedge clk_i);
		`VB_CHK("buzzer half", 1'b1, bz_n >= 1023 && bz_n <= 1025)
		wrap_up();
	end
endmodule // vcct_bench
`default_nettype wire

// *** verification/vcct_chk.sv ***
/* vcct_chk: wire checks of the two-wire control link.
   assumes host QTR of 4 on a 40 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module vcct_chk (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic scl,
	input wire logic sda,
	input wire logic cs,
	input wire logic sda_d_oe
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// slave side
	chk_cs_gates_slave: assert property ((!cs)[*3] |-> !sda_d_oe)
		else $error("slave drove sda while deselected");
	chk_slave_stable_high: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
		else $error("slave changed sda with scl high");
	chk_drive_starts_low: assert property ($rose(sda_d_oe) |-> !scl)
		else $error("slave drive began with scl high");
	chk_ack_held_high: assert property (sda_d_oe && $rose(scl) |-> (!sda)[*4])
		else $error("slave low not held through clock high");
	chk_slave_releases: assert property ($rose(sda_d_oe) |-> ##[1:200] !sda_d_oe)
		else $error("slave never released sda");
	// master side
	chk_start_by_master: assert property (scl && $past(scl) && $fell(sda) |-> !sda_d_oe)
		else $error("start made by slave");
	chk_scl_high_width: assert property ($rose(scl) |-> scl[*6])
		else $error("clock high too short");
	chk_scl_low_bound: assert property ($fell(scl) |-> (!scl)[*4] ##[1:8] scl)
		else $error("clock low too short or stuck");
endmodule // vcct_chk
`default_nettype wire
